// ===== dram_pkg.sv
// Package for the burst-interrupt and bank-closing block.
// Assumes a single 40 MHz command clock and a four-bank device.
package dram_pkg;
    localparam int NUM_BANKS = 4;
    localparam int DATA_BYTES = 2;
    localparam int BYTE_BITS = 8;
    localparam int DATA_BITS = DATA_BYTES * BYTE_BITS;
    localparam int CNT_W = 8;
    localparam real CLK_PERIOD_NS = 25.0;
    // Analog minimums in nanoseconds, plain defaults.
    localparam real RTP_TIME_NS = 7.5;
    localparam real RAS_TIME_NS = 45.0;
    localparam real RP_TIME_NS = 15.0;
    localparam real WR_TIME_NS = 15.0;
    // Least times round up to whole cycles, never below one.
    localparam logic [7:0] RTP_CYC =
        8'($ceil(RTP_TIME_NS / CLK_PERIOD_NS));
    localparam logic [7:0] RAS_CYC =
        8'($ceil(RAS_TIME_NS / CLK_PERIOD_NS));
    localparam logic [7:0] RP_CYC =
        8'($ceil(RP_TIME_NS / CLK_PERIOD_NS));
    localparam logic [7:0] WR_CYC =
        8'($ceil(WR_TIME_NS / CLK_PERIOD_NS));
    localparam logic [7:0] CCD_CYC = 8'h02;
    localparam logic [7:0] PREFETCH_GAP = 8'h02;
    localparam logic [7:0] ONE_CYC = 8'h01;
    localparam logic [2:0] BURST_CODE_4 = 3'h2;
    localparam logic [2:0] BURST_CODE_8 = 3'h3;
    localparam logic [7:0] HALF_BURST_4 = 8'h02;
    localparam logic [7:0] HALF_BURST_8 = 8'h04;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE
    } cmd_kind_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic auto_close_address_bit;
        logic bank_select_high;
        logic bank_select_low;
    } cmd_t;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic [DATA_BYTES-1:0] write_byte_mask;
        logic valid;
    } wbeat_t;

    typedef struct packed {
        logic [2:0] burst_code;
        logic [7:0] posted_delay;
        logic [7:0] column_access_latency;
    } mode_t;
endpackage : dram_pkg

// ===== bank_closer.sv
// One bank's open/close state and timing counters.
// Assumes commands arrive decoded and already addressed to this bank.
`timescale 1ns/1ps
`default_nettype none
module bank_closer
    import dram_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Command strobes for this bank.
    input wire logic act_in,
    input wire logic close_in,
    input wire logic auto_arm_in,
    input wire logic [7:0] auto_wait_in,
    input wire logic [7:0] auto_floor_in,
    // State.
    output logic open_out,
    output logic ras_met_out,
    output logic act_ok_out,
    output logic auto_pend_out
);
    logic open_reg, open_next;
    logic [7:0] ras_reg, ras_next;
    logic [7:0] rp_reg, rp_next;
    logic [7:0] auto_reg, auto_next;
    logic [7:0] floor_reg, floor_next;
    logic pend_reg, pend_next;
    wire ras_met = (ras_reg == 8'h00);
    wire auto_fire = pend_reg && auto_reg == 8'h00 && floor_reg == 8'h00
        && ras_met;
    // Each timer is loaded one short, so the guarded action lands on the
    // edge that meets the spacing instead of one edge after it.
    wire [7:0] wait_load = (auto_wait_in == 8'h00) ? 8'h00
        : auto_wait_in - ONE_CYC;
    wire [7:0] floor_load = (auto_floor_in == 8'h00) ? 8'h00
        : auto_floor_in - ONE_CYC;

    // Auto-close waits for burst end, the prefetch floor and activate minimum.
    always_comb begin
        open_next = open_reg;
        ras_next = ras_met ? ras_reg : ras_reg - ONE_CYC;
        rp_next = (rp_reg == 8'h00) ? rp_reg : rp_reg - ONE_CYC;
        auto_next = (auto_reg == 8'h00) ? auto_reg : auto_reg - ONE_CYC;
        floor_next = (floor_reg == 8'h00) ? floor_reg : floor_reg - ONE_CYC;
        pend_next = pend_reg;
        if (act_in) begin
            open_next = 1'b1;
            ras_next = RAS_CYC - ONE_CYC;
        end
        if (auto_arm_in) begin
            pend_next = 1'b1;
            auto_next = wait_load;
            floor_next = floor_load;
        end else if (auto_fire) begin
            pend_next = 1'b0;
            open_next = 1'b0;
            rp_next = RP_CYC - ONE_CYC;
        end
        if (close_in) begin
            open_next = 1'b0;
            rp_next = RP_CYC - ONE_CYC;
        end
    end

    // Short state update; all counters clear on reset.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            open_reg <= 1'b0;
            ras_reg <= 8'h00;
            rp_reg <= 8'h00;
            auto_reg <= 8'h00;
            floor_reg <= 8'h00;
            pend_reg <= 1'b0;
        end else begin
            open_reg <= open_next;
            ras_reg <= ras_next;
            rp_reg <= rp_next;
            auto_reg <= auto_next;
            floor_reg <= floor_next;
            pend_reg <= pend_next;
        end
    end

    assign open_out = open_reg;
    assign ras_met_out = ras_met;
    assign act_ok_out = !open_reg && !pend_reg && rp_reg == 8'h00;
    assign auto_pend_out = pend_reg;
endmodule : bank_closer
`default_nettype wire

// ===== dram_burst_ctrl.sv
// Burst interruption, write masking and bank closing for a four-bank DRAM.
// Assumes commands are already sampled on ref_clk_in by the command front end.
`timescale 1ns/1ps
`default_nettype none
module dram_burst_ctrl
    import dram_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Command bus.
    input wire cmd_t cmd_in,
    input wire mode_t mode_in,
    // Write data beats.
    input wire wbeat_t wbeat_in,
    // Array write port.
    output logic [DATA_BITS-1:0] array_data_out,
    output logic [DATA_BYTES-1:0] array_byte_en_out,
    output logic array_write_out,
    // Status.
    output logic [NUM_BANKS-1:0] bank_open_out,
    output logic [NUM_BANKS-1:0] activate_ok_out,
    output logic burst_active_out,
    output logic protocol_error_out
);
    // Mode-derived spacing.
    wire is_bl8 = (mode_in.burst_code == BURST_CODE_8);
    wire [7:0] half_burst = is_bl8 ? HALF_BURST_8 : HALF_BURST_4;
    wire [7:0] read_data_delay = mode_in.posted_delay
        + mode_in.column_access_latency;
    wire [7:0] write_data_delay = read_data_delay - ONE_CYC;
    wire [7:0] rtp_eff = (RTP_CYC > PREFETCH_GAP) ? RTP_CYC : PREFETCH_GAP;
    // Read auto-close: the burst end, and the last prefetch start plus the read-to-precharge floor.
    wire [7:0] read_close_wait = mode_in.posted_delay + half_burst;
    wire [7:0] prefetch_start = mode_in.posted_delay
        + (is_bl8 ? PREFETCH_GAP : 8'h00);
    wire [7:0] read_close_floor = prefetch_start + rtp_eff;
    wire [7:0] read_pre_min = mode_in.posted_delay + half_burst + rtp_eff
        - PREFETCH_GAP;
    wire [7:0] write_pre_min = write_data_delay + half_burst
        + WR_CYC;
    wire [7:0] write_close_wait = write_pre_min;

    // Command decode.
    wire [1:0] bank_sel = {cmd_in.bank_select_high, cmd_in.bank_select_low};
    wire is_act = cmd_in.kind == CMD_ACTIVATE;
    wire is_rd = cmd_in.kind == CMD_READ;
    wire is_wr = cmd_in.kind == CMD_WRITE;
    wire is_pre = cmd_in.kind == CMD_PRECHARGE;
    wire is_col = is_rd || is_wr;

    // Burst tracking.
    logic [7:0] burst_left_reg, burst_left_next;
    logic [7:0] since_col_reg, since_col_next;
    logic burst_is_wr_reg, burst_is_wr_next;
    logic burst_auto_reg, burst_auto_next;
    logic [7:0] pre_block_reg [NUM_BANKS];
    logic err_reg, err_next;
    wire in_burst = burst_left_reg != 8'h00;
    // A command on the last burst edge already follows the burst, so only
    // the edges before it count as a live burst that a command would cut.
    wire in_cut_zone = burst_left_reg > ONE_CYC;

    // Interruption legality.
    wire same_kind = (is_rd && !burst_is_wr_reg)
        || (is_wr && burst_is_wr_reg);
    wire col_legal = !in_cut_zone
        || (is_bl8
            && same_kind
            && since_col_reg == CCD_CYC
            && !burst_auto_reg);
    // Any bank may be addressed by the interrupting command.

    // Per-bank precharge legality and bank instances.
    logic [NUM_BANKS-1:0] pre_hit, act_hit, col_hit, arm_hit;
    logic [NUM_BANKS-1:0] ras_met, act_ok, pend, opened;
    logic [NUM_BANKS-1:0] pre_bad;
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            assign pre_hit[b] = is_pre && (cmd_in.auto_close_address_bit
                || bank_sel == 2'(b));
            assign act_hit[b] = is_act && bank_sel == 2'(b);
            assign col_hit[b] = is_col && bank_sel == 2'(b);
            assign arm_hit[b] = col_hit[b] && cmd_in.auto_close_address_bit
                && col_legal;
            assign pre_bad[b] = pre_hit[b] && opened[b]
                && (!ras_met[b] || pre_block_reg[b] != 8'h00);
            bank_closer u_bank (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .act_in(act_hit[b]),
                .close_in(pre_hit[b]),
                .auto_arm_in(arm_hit[b]),
                .auto_wait_in(is_wr ? write_close_wait : read_close_wait),
                .auto_floor_in(is_wr ? 8'h00 : read_close_floor),
                .open_out(opened[b]),
                .ras_met_out(ras_met[b]),
                .act_ok_out(act_ok[b]),
                .auto_pend_out(pend[b])
            );
            // Precharge spacing after a column command to this bank.
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    pre_block_reg[b] <= 8'h00;
                end else if (col_hit[b]) begin
                    // Loaded one short so the minimum spacing itself is legal.
                    pre_block_reg[b] <= (is_wr ? write_pre_min
                        : read_pre_min) - ONE_CYC;
                end else if (pre_block_reg[b] != 8'h00) begin
                    pre_block_reg[b] <= pre_block_reg[b] - ONE_CYC;
                end
            end
        end
    endgenerate

    // An activate to a bank that is open or still recovering is an error.
    wire act_bad = is_act && !act_ok[bank_sel];
    wire pre_in_burst = is_pre && in_cut_zone;
    wire col_bad = is_col && !col_legal;
    wire any_err = act_bad || (|pre_bad) || pre_in_burst || col_bad;

    // Burst bookkeeping; counts span the programmed burst even when cut.
    always_comb begin
        burst_left_next = in_burst ? burst_left_reg - ONE_CYC : 8'h00;
        since_col_next = (since_col_reg == 8'hff) ? since_col_reg
            : since_col_reg + ONE_CYC;
        burst_is_wr_next = burst_is_wr_reg;
        burst_auto_next = burst_auto_reg;
        err_next = err_reg || any_err;
        if (is_col) begin
            burst_left_next = half_burst;
            since_col_next = ONE_CYC;
            burst_is_wr_next = is_wr;
            burst_auto_next = cmd_in.auto_close_address_bit;
        end
    end

    // Sticky error and burst state, short by design.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            burst_left_reg <= 8'h00;
            since_col_reg <= 8'hff;
            burst_is_wr_reg <= 1'b0;
            burst_auto_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            burst_left_reg <= burst_left_next;
            since_col_reg <= since_col_next;
            burst_is_wr_reg <= burst_is_wr_next;
            burst_auto_reg <= burst_auto_next;
            err_reg <= err_next;
        end
    end

    // Write beats: the mask gates bytes only while a write burst is live.
    // Beats outside a write burst are dropped, so read-time masks do nothing.
    wire beat_take = wbeat_in.valid && in_burst && burst_is_wr_reg;
    logic [DATA_BITS-1:0] data_reg;
    logic [DATA_BYTES-1:0] be_reg;
    logic wr_reg;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            data_reg <= '0;
            be_reg <= '0;
            wr_reg <= 1'b0;
        end else begin
            data_reg <= wbeat_in.data;
            be_reg <= beat_take ? ~wbeat_in.write_byte_mask : '0;
            wr_reg <= beat_take;
        end
    end

    assign array_data_out = data_reg;
    assign array_byte_en_out = be_reg;
    assign array_write_out = wr_reg;
    assign bank_open_out = opened;
    assign activate_ok_out = act_ok;
    assign burst_active_out = in_burst;
    assign protocol_error_out = err_reg;
endmodule : dram_burst_ctrl
`default_nettype wire

// ===== dram_burst_ctrl_checker.sv
// Checker for the burst-interrupt and bank-closing block.
// Sees only the ports of dram_burst_ctrl and is bound to it below.
`timescale 1ns/1ps
`default_nettype none
module dram_burst_ctrl_checker
    import dram_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Inputs of the block.
    input wire cmd_t cmd_in,
    input wire mode_t mode_in,
    input wire wbeat_t wbeat_in,
    // Outputs of the block.
    input wire logic [DATA_BITS-1:0] array_data_out,
    input wire logic [DATA_BYTES-1:0] array_byte_en_out,
    input wire logic array_write_out,
    input wire logic [NUM_BANKS-1:0] bank_open_out,
    input wire logic [NUM_BANKS-1:0] activate_ok_out,
    input wire logic burst_active_out,
    input wire logic protocol_error_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Decoded command fields shared by the properties.
    wire logic [1:0] bank = {cmd_in.bank_select_high, cmd_in.bank_select_low};
    wire logic col = cmd_in.kind == CMD_READ || cmd_in.kind == CMD_WRITE;
    wire logic is8 = mode_in.burst_code == BURST_CODE_8;
    wire logic pre = cmd_in.kind == CMD_PRECHARGE;
    wire logic act = cmd_in.kind == CMD_ACTIVATE;

    chk_mask_bytes: assert property (
        array_write_out |-> array_byte_en_out ==
        ~$past(wbeat_in.write_byte_mask)) else $error("byte enables wrong");
    chk_beat_data: assert property (
        array_write_out |-> $past(wbeat_in.valid) &&
        array_data_out == $past(wbeat_in.data)) else $error("array data wrong");
    chk_idle_bytes: assert property (
        !array_write_out |-> array_byte_en_out == 2'h0)
        else $error("byte enables without a write");
    chk_close_one: assert property (
        pre && !cmd_in.auto_close_address_bit |=> !bank_open_out[$past(bank)])
        else $error("selected bank stayed open");
    chk_close_all: assert property (
        pre && cmd_in.auto_close_address_bit |=> bank_open_out == 4'h0)
        else $error("a bank stayed open after close all");
    chk_burst_run: assert property (
        col && !burst_active_out |=> burst_active_out [*2])
        else $error("burst shorter than two cycles");
    chk_burst_eight: assert property (
        col && is8 && !burst_active_out |=> burst_active_out [*4])
        else $error("burst of eight cut short");
    chk_err_sticky: assert property (
        protocol_error_out |=> protocol_error_out) else $error("error cleared");
    chk_spacing_one: assert property (
        col && $past(col) |=> protocol_error_out)
        else $error("one-cycle column spacing accepted");
    chk_read_cut: assert property (
        cmd_in.kind == CMD_WRITE && $past(cmd_in.kind, 2) == CMD_READ && is8
        |=> protocol_error_out) else $error("write cut a read burst");
    chk_act_refused: assert property (
        act && !activate_ok_out[bank] |=> protocol_error_out)
        else $error("early activate accepted");
    // Main scenarios that the bench is expected to reach.
    cover property (col && is8 ##2 col);
    cover property (pre && cmd_in.auto_close_address_bit);
    cover property (array_write_out && array_byte_en_out == 2'h1);
endmodule : dram_burst_ctrl_checker
bind dram_burst_ctrl dram_burst_ctrl_checker u_dram_burst_ctrl_checker (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
    .mode_in(mode_in), .wbeat_in(wbeat_in), .array_data_out(array_data_out),
    .array_byte_en_out(array_byte_en_out), .array_write_out(array_write_out),
    .bank_open_out(bank_open_out), .activate_ok_out(activate_ok_out),
    .burst_active_out(burst_active_out),
    .protocol_error_out(protocol_error_out));
`default_nettype wire

// ===== dram_ctrl_model.sv
// Controller-side model: drives commands and write beats to the block.
// Assumes the bench calls step once per cycle; changes land on falling edges.
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model
    import dram_pkg::*;
(
    // Clock.
    input wire logic ref_clk_in,
    // Command and data towards the block.
    output var cmd_t cmd_out,
    output var wbeat_t wbeat_out
);
    // Start idle so the block sees no command during reset.
    initial begin
        cmd_out = '{CMD_NOP, 1'b0, 1'b0, 1'b0};
        wbeat_out = '0;
    end
    // One cycle of command and beat; the mask covers eight data lines per
    // bit. A released data bus toggles so stale data never looks fresh.
    task automatic step(input cmd_kind_t k, input logic ap,
                        input logic [1:0] b, input logic v,
                        input logic [DATA_BITS-1:0] d,
                        input logic [DATA_BYTES-1:0] m);
        @(negedge ref_clk_in);
        cmd_out = '{k, ap, b[1], b[0]};
        if (v) wbeat_out = '{d, m, 1'b1};
        else wbeat_out = '{~wbeat_out.data, ~wbeat_out.write_byte_mask, 1'b0};
    endtask : step
endmodule : dram_ctrl_model
`default_nettype wire

// ===== dram_burst_ctrl_test.sv
// Self-checking bench for the burst-interrupt and bank-closing block.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dram_burst_ctrl_test
    import dram_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    mode_t mode_in = '{BURST_CODE_4, 8'h00, 8'h03};
    cmd_t cmd_in;
    wbeat_t wbeat_in;
    logic [DATA_BITS-1:0] array_data_out, d;
    logic [DATA_BYTES-1:0] array_byte_en_out, m;
    logic array_write_out, burst_active_out, protocol_error_out;
    logic [NUM_BANKS-1:0] bank_open_out, activate_ok_out;
    logic [DATA_BITS+DATA_BYTES-1:0] expq[$], exp_w;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    // The 40 MHz command clock.
    always #12.5 ref_clk_in = ~ref_clk_in;
    dram_ctrl_model u_dram_ctrl_model (.ref_clk_in(ref_clk_in),
        .cmd_out(cmd_in), .wbeat_out(wbeat_in));
    dram_burst_ctrl u_dram_burst_ctrl (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .cmd_in(cmd_in), .mode_in(mode_in),
        .wbeat_in(wbeat_in), .array_data_out(array_data_out),
        .array_byte_en_out(array_byte_en_out),
        .array_write_out(array_write_out), .bank_open_out(bank_open_out),
        .activate_ok_out(activate_ok_out),
        .burst_active_out(burst_active_out),
        .protocol_error_out(protocol_error_out));
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Reset for four cycles; the burst size only changes while in reset.
    task automatic do_reset(input logic [2:0] code);
        @(negedge ref_clk_in);
        rst_n_in = 1'b0;
        mode_in.burst_code = code;
        expq.delete();
        repeat (4) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
    endtask : do_reset
    task automatic op(input cmd_kind_t k, input logic ap, input logic [1:0] b,
                      input int gap);
        u_dram_ctrl_model.step(k, ap, b, 1'b0, '0, '0);
        repeat (gap) u_dram_ctrl_model.step(CMD_NOP, 1'b0, 2'h0, 1'b0, '0, '0);
    endtask : op
    // A first column command on bank zero, then a second command on bank one.
    task automatic cut(input logic [2:0] code, input cmd_kind_t k1,
                       input logic ap1, input int gap, input cmd_kind_t k2,
                       input logic ap2, input logic err);
        do_reset(code);
        op(CMD_ACTIVATE, 1'b0, 2'h0, 0);
        op(CMD_ACTIVATE, 1'b0, 2'h1, 3);
        op(k1, ap1, 2'h0, gap - 1);
        op(k2, ap2, 2'h1, 3);
        check(protocol_error_out === err, "interruption verdict");
    endtask : cut
    // An activate, or an activate and a write, then a precharge to bank 0.
    task automatic early_pre(input cmd_kind_t k, input int gap,
                             input logic err);
        do_reset(BURST_CODE_4);
        op(CMD_ACTIVATE, 1'b0, 2'h0, k == CMD_ACTIVATE ? gap : 3);
        if (k != CMD_ACTIVATE) op(k, 1'b0, 2'h0, gap);
        op(CMD_PRECHARGE, 1'b0, 2'h0, 2);
        check(protocol_error_out === err, "precharge verdict");
    endtask : early_pre
    // Each array write is matched against the oldest noted beat.
    always @(posedge ref_clk_in) begin
        if (array_write_out === 1'b1) begin
            if (expq.size() == 0) begin
                check(1'b0, "array write without a beat");
            end else begin
                exp_w = expq.pop_front();
                check({array_data_out, array_byte_en_out} === exp_w, "beat");
            end
        end
    end
    // Main sequence: masking, closing, auto-close, interruptions, then early precharges.
    initial begin
        void'($urandom(32'h5e96));
        do_reset(BURST_CODE_4);
        for (int b = 0; b < 4; b++) op(CMD_ACTIVATE, 1'b0, 2'(b), 0);
        op(CMD_NOP, 1'b0, 2'h0, 1);
        for (int i = 0; i < 6; i++) begin
            d = DATA_BITS'($urandom);
            m = 2'(i - i / 3 - 1);
            if (i % 3 != 0) expq.push_back({d, ~m});
            u_dram_ctrl_model.step(i % 3 == 0 ? CMD_WRITE : CMD_NOP, 1'b0,
                2'h1, i % 3 != 0, d, m);
        end
        op(CMD_NOP, 1'b0, 2'h0, 5);
        check(expq.size() == 0, "beats not all written");
        op(CMD_PRECHARGE, 1'b0, 2'h2, 2);
        check(bank_open_out === 4'hb, "single bank close");
        op(CMD_PRECHARGE, 1'b0, 2'h1, 2);
        check(bank_open_out === 4'h9, "written bank close");
        u_dram_ctrl_model.step(CMD_READ, 1'b0, 2'h0, 1'b1, 16'ha5a5, 2'h0);
        repeat (2) u_dram_ctrl_model.step(CMD_NOP, 1'b0, 2'h0, 1'b1,
            DATA_BITS'($urandom), 2'h0);
        check(burst_active_out === 1'b1, "read burst ended early");
        op(CMD_NOP, 1'b0, 2'h0, 0);
        check(burst_active_out === 1'b0, "read burst too long");
        op(CMD_NOP, 1'b0, 2'h0, 3);
        op(CMD_PRECHARGE, 1'b1, 2'h2, 2);
        check(bank_open_out === 4'h0, "close all");
        check(protocol_error_out === 1'b0, "legal traffic flagged");
        op(CMD_NOP, 1'b0, 2'h0, 3);
        check(activate_ok_out === 4'hf, "banks ready again");
        for (int j = 0; j < 2; j++) begin
            op(CMD_ACTIVATE, 1'b0, 2'h0, 2);
            op(j == 1 ? CMD_READ : CMD_WRITE, 1'b1, 2'h0, 0);
            n = 0;
            while (bank_open_out[0] !== 1'b0 && n < 40) begin
                op(CMD_NOP, 1'b0, 2'h0, 0);
                n++;
            end
            check(n == (j == 1 ? 3 : 6), "auto-close time");
            if (n >= 40) wrap_up();
            op(CMD_NOP, 1'b0, 2'h0, 3);
        end
        check(protocol_error_out === 1'b0, "auto-close flagged");
        cut(BURST_CODE_8, CMD_READ, 1'b0, 2, CMD_READ, 1'b0, 1'b0);
        cut(BURST_CODE_8, CMD_WRITE, 1'b0, 2, CMD_WRITE, 1'b1, 1'b0);
        cut(BURST_CODE_8, CMD_READ, 1'b0, 2, CMD_WRITE, 1'b0, 1'b1);
        cut(BURST_CODE_8, CMD_READ, 1'b0, 2, CMD_PRECHARGE, 1'b0, 1'b1);
        cut(BURST_CODE_8, CMD_WRITE, 1'b0, 2, CMD_READ, 1'b0, 1'b1);
        cut(BURST_CODE_8, CMD_READ, 1'b0, 3, CMD_READ, 1'b0, 1'b1);
        cut(BURST_CODE_8, CMD_READ, 1'b1, 2, CMD_READ, 1'b0, 1'b1);
        cut(BURST_CODE_4, CMD_READ, 1'b0, 1, CMD_READ, 1'b0, 1'b1);
        cut(BURST_CODE_8, CMD_READ, 1'b0, 2, CMD_ACTIVATE, 1'b0, 1'b1);
        cut(BURST_CODE_4, CMD_READ, 1'b0, 2, CMD_READ, 1'b0, 1'b0);
        early_pre(CMD_ACTIVATE, 0, 1'b1);
        early_pre(CMD_WRITE, 2, 1'b1);
        early_pre(CMD_WRITE, 4, 1'b0);
        wrap_up();
    end
endmodule : dram_burst_ctrl_test
`default_nettype wire
